/* rtl/fcs_sequencer.sv */
// Flash charger sequencer: session control, switch timing, modes and register slave
module fcs_sequencer
    import fcs_pkg::*;
#(
    parameter int SW_TIMEOUT = SW_TIMEOUT_CYC,
    parameter int LIMIT_SETUP = LIMIT_SETUP_CYC,
    parameter int SENSE_MIN = SENSE_MIN_CYC
) (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic reset_i,
    // Host pins
    input wire logic charge_req_i,
    input wire logic flash_fire_input_i,
    // Analog comparators
    input wire logic supply_lockout_i,
    input wire logic peak_current_limit_i,
    input wire logic output_trip_level_i,
    input wire logic flux_reset_i,
    input wire logic low_output_i,
    // Power switch and flash drivers
    output logic switch_node_on_o,
    output logic flash_gate_o,
    output logic [CODE_W-1:0] peak_limit_code_o,
    // Open-drain completion flag
    input wire logic done_n_i,
    output logic done_n_o,
    output logic done_n_oe_o,
    // Avalon-MM slave
    input wire logic [AV_ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [AV_DATA_W-1:0] avs_writedata,
    output logic [AV_DATA_W-1:0] avs_readdata,
    output logic avs_waitrequest
);
    fcs_core_s st_ff;
    fcs_core_s nxt_st;
    fcs_pins_s pins_raw;
    fcs_pins_s pins_s;
    logic [CODE_W-1:0] code;
    logic rise;
    logic start;
    logic dec_clear;
    logic dec_edge;

    // Counter has run lim cycles in the current state
    function automatic logic reached(input logic [CNT_W-1:0] cnt, input int lim);
        reached = (cnt >= CNT_W'(lim - 1));
    endfunction : reached

    function automatic logic [AV_DATA_W-1:0] read_reg(
        input logic [AV_ADDR_W-1:0] addr,
        input fcs_core_s s,
        input logic [CODE_W-1:0] c,
        input logic done_pin
    );
        logic [AV_DATA_W-1:0] d;
        d = '0;
        unique case (addr)
            REG_CTRL_OFS: begin
                d[CTRL_FAST_EN_BIT] = s.fast_en;
            end
            REG_STATUS_OFS: begin
                d[ST_STATE_LSB +: $bits(fcs_state_e)] = s.state;
                d[ST_MODE_BIT] = s.mode;
                d[ST_CODE_LSB +: CODE_W] = c;
                d[ST_DONE_BIT] = s.done_oe;
                d[ST_DONE_PIN_BIT] = done_pin;
            end
            default: begin
                d = '0;
            end
        endcase
        read_reg = d;
    endfunction : read_reg

    assign pins_raw = '{
        charge: charge_req_i,
        fire: flash_fire_input_i,
        lockout: supply_lockout_i,
        peak: peak_current_limit_i,
        trip: output_trip_level_i,
        flux: flux_reset_i,
        low_out: low_output_i,
        done_pin: done_n_i
    };

    fcs_sync #(
        .W($bits(fcs_pins_s))
    ) u_sync (
        .ref_clk_i(ref_clk_i),
        .reset_i(reset_i),
        .d_i(pins_raw),
        .q_o(pins_s)
    );

    assign rise = pins_s.charge && !st_ff.charge_q;
    assign start = (st_ff.state == ST_IDLE) && rise && !pins_s.lockout;
    assign dec_clear = pins_s.lockout || ((st_ff.state == ST_IDLE) && !start);
    assign dec_edge = start || ((st_ff.state == ST_SETUP) && rise);

    fcs_limit_decoder u_dec (
        .ref_clk_i(ref_clk_i),
        .reset_i(reset_i),
        .clear_i(dec_clear),
        .edge_i(dec_edge),
        .peak_limit_code_o(code)
    );

    always_comb begin
        nxt_st = st_ff;
        nxt_st.charge_q = pins_s.charge;
        nxt_st.cnt = st_ff.cnt + 1'b1;
        nxt_st.flash = pins_s.fire;
        nxt_st.done_lvl = 1'b0;
        unique case (st_ff.state)
            ST_IDLE: begin
                nxt_st.cnt = '0;
                if (start) begin
                    nxt_st.state = ST_SETUP;
                    nxt_st.mode = MODE_TIMER;
                end
            end
            ST_SETUP: begin
                // Charge request toggles here while the limit is programmed
                if (reached(st_ff.cnt, LIMIT_SETUP)) begin
                    nxt_st.cnt = '0;
                    nxt_st.state = pins_s.charge ? ST_ON : ST_IDLE;
                end
            end
            ST_ON: begin
                if (pins_s.peak || reached(st_ff.cnt, SW_TIMEOUT)) begin
                    nxt_st.cnt = '0;
                    nxt_st.state = ST_OFF;
                end
            end
            ST_OFF: begin
                if (st_ff.cnt == CNT_W'(SENSE_MIN - 1) && pins_s.trip) begin
                    nxt_st.state = ST_DONE;
                end else begin
                    if (st_ff.cnt == CNT_W'(SENSE_MIN - 1) && !pins_s.low_out
                            && st_ff.fast_en) begin
                        nxt_st.mode = MODE_FAST;
                    end
                    if (reached(st_ff.cnt, SW_TIMEOUT)) begin
                        nxt_st.cnt = '0;
                        nxt_st.state = ST_ON;
                    end else if (st_ff.mode == MODE_FAST && pins_s.flux) begin
                        nxt_st.cnt = '0;
                        nxt_st.state = ST_ON;
                    end
                end
            end
            ST_DONE: begin
                nxt_st.cnt = '0;
            end
        endcase
        if (!pins_s.charge && st_ff.state != ST_SETUP) begin
            nxt_st.state = ST_IDLE;
            nxt_st.cnt = '0;
        end
        if (pins_s.lockout) begin
            nxt_st.state = ST_IDLE;
            nxt_st.mode = MODE_TIMER;
            nxt_st.cnt = '0;
        end
        nxt_st.switch_on = (nxt_st.state == ST_ON);
        nxt_st.done_oe = (nxt_st.state == ST_DONE) && pins_s.charge;

        // Register slave: one wait cycle, then the accept cycle
        nxt_st.waitreq = !((avs_read || avs_write) && st_ff.waitreq);
        if ((avs_read || avs_write) && st_ff.waitreq) begin
            nxt_st.rdata = read_reg(avs_address, st_ff, code, pins_s.done_pin);
        end
        if (avs_write && !st_ff.waitreq && avs_address == REG_CTRL_OFS) begin
            nxt_st.fast_en = avs_writedata[CTRL_FAST_EN_BIT];
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            st_ff <= '{
                state: ST_IDLE,
                mode: MODE_TIMER,
                cnt: '0,
                charge_q: 1'b0,
                fast_en: CTRL_FAST_EN_RESET,
                waitreq: 1'b1,
                rdata: '0,
                switch_on: 1'b0,
                flash: 1'b0,
                done_oe: 1'b0,
                done_lvl: 1'b0
            };
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign switch_node_on_o = st_ff.switch_on;
    assign flash_gate_o = st_ff.flash;
    assign peak_limit_code_o = code;
    assign done_n_o = st_ff.done_lvl;
    assign done_n_oe_o = st_ff.done_oe;
    assign avs_readdata = st_ff.rdata;
    assign avs_waitrequest = st_ff.waitreq;

    // Length of the current on interval, for checking only
    logic [CNT_W-1:0] on_run_ff;
    always_ff @(posedge ref_clk_i) begin
        if (reset_i || !switch_node_on_o) begin
            on_run_ff <= '0;
        end else if (on_run_ff != '1) begin
            on_run_ff <= on_run_ff + 1'b1;
        end
    end

    property p_flash_follows;
        @(posedge ref_clk_i) disable iff (reset_i)
        ##1 flash_gate_o == $past(pins_s.fire);
    endproperty
    a_flash_follows: assert property (p_flash_follows)
        else $error("Flash gate does not follow the fire input");

    property p_standby;
        @(posedge ref_clk_i) disable iff (reset_i)
        (!pins_s.charge && st_ff.state != ST_SETUP) |=>
            st_ff.state == ST_IDLE && !switch_node_on_o && !done_n_oe_o;
    endproperty
    a_standby: assert property (p_standby)
        else $error("Activity continued with charge request low");

    property p_lockout_reset;
        @(posedge ref_clk_i) disable iff (reset_i)
        pins_s.lockout |=> st_ff.state == ST_IDLE && st_ff.mode == MODE_TIMER
            ##1 peak_limit_code_o == CODE_FULL_SCALE;
    endproperty
    a_lockout_reset: assert property (p_lockout_reset)
        else $error("Lockout did not reset the control state");

    property p_peak_off;
        @(posedge ref_clk_i) disable iff (reset_i)
        (st_ff.state == ST_ON && pins_s.peak) |=> !switch_node_on_o;
    endproperty
    a_peak_off: assert property (p_peak_off)
        else $error("Switch stayed on at the current limit");

    property p_on_timeout;
        @(posedge ref_clk_i) disable iff (reset_i)
        switch_node_on_o |-> on_run_ff < CNT_W'(SW_TIMEOUT);
    endproperty
    a_on_timeout: assert property (p_on_timeout)
        else $error("On interval exceeded the timeout");

    property p_done_needs_charge;
        @(posedge ref_clk_i) disable iff (reset_i)
        done_n_oe_o |-> $past(pins_s.charge) && !switch_node_on_o;
    endproperty
    a_done_needs_charge: assert property (p_done_needs_charge)
        else $error("Completion flag without charge request or while switching");

    property p_setup_quiet;
        @(posedge ref_clk_i) disable iff (reset_i)
        $rose(switch_node_on_o) && $past(st_ff.state) == ST_SETUP |->
            $past(st_ff.cnt) == CNT_W'(LIMIT_SETUP - 1);
    endproperty
    a_setup_quiet: assert property (p_setup_quiet)
        else $error("Switching began before the setup period ended");

    property p_level_no_start;
        @(posedge ref_clk_i) disable iff (reset_i)
        (st_ff.state == ST_IDLE && !rise) |=> st_ff.state == ST_IDLE;
    endproperty
    a_level_no_start: assert property (p_level_no_start)
        else $error("Session started without a fresh edge");

    property p_trip_stop;
        @(posedge ref_clk_i) disable iff (reset_i)
        (st_ff.state == ST_OFF && st_ff.cnt == CNT_W'(SENSE_MIN - 1) && pins_s.trip
            && pins_s.charge && !pins_s.lockout) |=>
            st_ff.state == ST_DONE ##1 done_n_oe_o || !$past(pins_s.charge);
    endproperty
    a_trip_stop: assert property (p_trip_stop)
        else $error("Target reached but charging went on");
endmodule : fcs_sequencer

/* include/fcs_pkg.sv */
// Shared constants, timing counts, states and carriers of the flash charger sequencer
package fcs_pkg;
    // Time base
    localparam int CLK_MHZ = 250;
    localparam int T_SW_TIMEOUT_NS = 18000;
    localparam int T_LIMIT_SETUP_NS = 200000;
    localparam int T_SENSE_MIN_NS = 200;
    // Longest times round down, least times round up
    localparam int SW_TIMEOUT_CYC = T_SW_TIMEOUT_NS * CLK_MHZ / 1000;
    localparam int LIMIT_SETUP_CYC = T_LIMIT_SETUP_NS * CLK_MHZ / 1000;
    localparam int SENSE_MIN_CYC = (T_SENSE_MIN_NS * CLK_MHZ + 999) / 1000;
    localparam int CNT_W = 16;
    localparam int SYNC_STAGES = 2;

    // Peak limit code: 0 is full scale, each step lowers the limit
    localparam int CODE_W = 4;
    localparam logic [CODE_W-1:0] CODE_FULL_SCALE = 4'h0;
    localparam logic [CODE_W-1:0] CODE_MAX = 4'hf;

    // Register bus
    localparam int AV_ADDR_W = 4;
    localparam int AV_DATA_W = 32;
    localparam logic [AV_ADDR_W-1:0] REG_CTRL_OFS = 4'h0;
    localparam logic [AV_ADDR_W-1:0] REG_STATUS_OFS = 4'h4;
    localparam int CTRL_FAST_EN_BIT = 0;
    localparam logic CTRL_FAST_EN_RESET = 1'h1;
    localparam int ST_STATE_LSB = 0;
    localparam int ST_MODE_BIT = 4;
    localparam int ST_CODE_LSB = 8;
    localparam int ST_DONE_BIT = 12;
    localparam int ST_DONE_PIN_BIT = 13;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_SETUP,
        ST_ON,
        ST_OFF,
        ST_DONE
    } fcs_state_e;

    typedef enum logic {
        MODE_TIMER,
        MODE_FAST
    } fcs_mode_e;

    // Asynchronous pin and comparator inputs, synchronized as one group
    typedef struct packed {
        logic charge;
        logic fire;
        logic lockout;
        logic peak;
        logic trip;
        logic flux;
        logic low_out;
        logic done_pin;
    } fcs_pins_s;

    typedef struct packed {
        fcs_state_e state;
        fcs_mode_e mode;
        logic [CNT_W-1:0] cnt;
        logic charge_q;
        logic fast_en;
        logic waitreq;
        logic [AV_DATA_W-1:0] rdata;
        logic switch_on;
        logic flash;
        logic done_oe;
        logic done_lvl;
    } fcs_core_s;
endpackage : fcs_pkg

/* rtl/fcs_sync.sv */
// Two-stage level synchronizer for a group of asynchronous inputs
module fcs_sync
    import fcs_pkg::*;
#(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic reset_i,
    // Levels
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [SYNC_STAGES-1:0][W-1:0] st_ff;
    logic [SYNC_STAGES-1:0][W-1:0] nxt_st;

    always_comb begin
        nxt_st = {st_ff[0], d_i};
    end

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign q_o = st_ff[SYNC_STAGES-1];
endmodule : fcs_sync

/* rtl/fcs_limit_decoder.sv */
// Pulse-count decoder for the peak limit code
module fcs_limit_decoder
    import fcs_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic reset_i,
    // Control
    input wire logic clear_i,
    input wire logic edge_i,
    // Result
    output logic [CODE_W-1:0] peak_limit_code_o
);
    typedef struct packed {
        logic started;
        logic [CODE_W-1:0] code;
    } fcs_dec_s;

    fcs_dec_s st_ff;
    fcs_dec_s nxt_st;

    always_comb begin
        nxt_st = st_ff;
        if (clear_i) begin
            nxt_st.started = 1'b0;
            nxt_st.code = CODE_FULL_SCALE;
        end else if (edge_i) begin
            nxt_st.started = 1'b1;
            if (st_ff.started && st_ff.code != CODE_MAX) begin
                nxt_st.code = st_ff.code + 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            st_ff <= '{started: 1'b0, code: CODE_FULL_SCALE};
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign peak_limit_code_o = st_ff.code;

    property p_code_monotonic;
        @(posedge ref_clk_i) disable iff (reset_i)
        !clear_i |=> peak_limit_code_o >= $past(peak_limit_code_o);
    endproperty
    a_code_monotonic: assert property (p_code_monotonic)
        else $error("Limit code fell without a clear");

    property p_first_edge_full;
        @(posedge ref_clk_i) disable iff (reset_i)
        clear_i ##1 (edge_i && !clear_i) |=> peak_limit_code_o == CODE_FULL_SCALE;
    endproperty
    a_first_edge_full: assert property (p_first_edge_full)
        else $error("First edge after clear moved the limit code");
endmodule : fcs_limit_decoder

/* testbench/fcs_host_model.sv */
// Host model driving the charge request and fire pins
module fcs_host_model (
    // Clock
    input wire logic ref_clk_i,
    // Host pins
    output logic charge_req_o,
    output logic flash_fire_o
);
    timeunit 1ns;
    timeprecision 1ps;

    // Charge request held low through power-up
    initial begin
        charge_req_o = 1'b0;
        flash_fire_o = 1'b0;
    end

    // Rising edge, long first pulse, then short pulses; stays high after
    task automatic burst(input int extra);
        int i;
        @(posedge ref_clk_i) charge_req_o <= 1'b1;
        repeat (16) @(posedge ref_clk_i);
        for (i = 0; i < extra; i++) begin
            charge_req_o <= 1'b0;
            repeat (4) @(posedge ref_clk_i);
            charge_req_o <= 1'b1;
            repeat (4) @(posedge ref_clk_i);
        end
        // Whole burst ends well inside the setup window
    endtask : burst

    // Low clears the code before any new burst
    task automatic drop();
        @(posedge ref_clk_i) charge_req_o <= 1'b0;
        repeat (8) @(posedge ref_clk_i);
    endtask : drop

    // Fire only used while no session is charging
    task automatic set_fire(input logic v);
        @(posedge ref_clk_i) flash_fire_o <= v;
    endtask : set_fire
endmodule : fcs_host_model

/* testbench/flash_charger_sequencer_tb.sv */
// Self-checking bench of the flash charger sequencer
module flash_charger_sequencer_tb
    import fcs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int SW = 40;
    localparam int SETUP = 200;
    localparam int SENSE = 4;

    logic ref_clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic charge_req_i;
    logic flash_fire_input_i;
    logic supply_lockout_i;
    logic peak_current_limit_i;
    logic output_trip_level_i;
    logic flux_reset_i;
    logic low_output_i;
    logic switch_node_on_o;
    logic flash_gate_o;
    logic [CODE_W-1:0] peak_limit_code_o;
    logic done_n_i;
    logic done_n_o;
    logic done_n_oe_o;
    logic [AV_ADDR_W-1:0] avs_address;
    logic avs_read;
    logic avs_write;
    logic [AV_DATA_W-1:0] avs_writedata;
    logic [AV_DATA_W-1:0] avs_readdata;
    logic avs_waitrequest;
    logic [AV_DATA_W-1:0] rd;
    int err_count = 0;
    int compares = 0;
    int cyc = 0;
    int n;

    always #2 ref_clk_i = ~ref_clk_i;
    // Completion wire with pull-up
    assign done_n_i = done_n_oe_o ? done_n_o : 1'b1;

    fcs_sequencer #(.SW_TIMEOUT(SW), .LIMIT_SETUP(SETUP), .SENSE_MIN(SENSE)) u_fcs_sequencer (
        .ref_clk_i(ref_clk_i), .reset_i(reset_i), .charge_req_i(charge_req_i),
        .flash_fire_input_i(flash_fire_input_i), .supply_lockout_i(supply_lockout_i),
        .peak_current_limit_i(peak_current_limit_i), .output_trip_level_i(output_trip_level_i),
        .flux_reset_i(flux_reset_i), .low_output_i(low_output_i),
        .switch_node_on_o(switch_node_on_o), .flash_gate_o(flash_gate_o),
        .peak_limit_code_o(peak_limit_code_o), .done_n_i(done_n_i), .done_n_o(done_n_o),
        .done_n_oe_o(done_n_oe_o), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest));

    fcs_host_model u_fcs_host_model (
        .ref_clk_i(ref_clk_i), .charge_req_o(charge_req_i), .flash_fire_o(flash_fire_input_i));

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : conclude

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic in_range(input int v, input int lo, input int hi);
        check(32'(v >= lo && v <= hi), 32'h1);
    endtask : in_range

    // Bus cycle held until waitrequest is seen low at a rising edge
    task automatic av_cycle(input logic wr, input logic [3:0] a, input logic [31:0] wd,
                            output logic [31:0] d);
        int k;
        @(posedge ref_clk_i);
        avs_address <= a;
        avs_writedata <= wd;
        avs_write <= wr;
        avs_read <= ~wr;
        k = 0;
        do begin
            @(posedge ref_clk_i);
            k++;
        end while (avs_waitrequest !== 1'b0 && k < 50);
        d = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        if (k >= 50) check(32'h0, 32'h1);
    endtask : av_cycle

    // Cycles until the chosen output reaches v: 0 switch, 1 completion enable
    task automatic wait_sig(input int sel, input logic v, output int cnt);
        cnt = 0;
        while ((sel == 0 ? switch_node_on_o : done_n_oe_o) !== v && cnt < 500) begin
            @(negedge ref_clk_i);
            cnt++;
        end
        if (cnt >= 500) check(32'h0, 32'h1);
    endtask : wait_sig

    // Cut an on interval by the current comparator
    task automatic pk();
        int c;
        repeat (3) @(posedge ref_clk_i);
        peak_current_limit_i <= 1'b1;
        wait_sig(0, 1'b0, c);
        in_range(c, 1, 6);
        @(posedge ref_clk_i) peak_current_limit_i <= 1'b0;
    endtask : pk

    always @(posedge ref_clk_i) begin
        cyc <= cyc + 1;
        if (cyc > 20000) begin
            err_count++;
            conclude();
        end
    end

    initial begin
        supply_lockout_i <= 1'b0;
        peak_current_limit_i <= 1'b0;
        output_trip_level_i <= 1'b0;
        flux_reset_i <= 1'b0;
        low_output_i <= 1'b1;
        avs_address <= '0;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        avs_writedata <= '0;
        repeat (10) @(posedge ref_clk_i);
        reset_i <= 1'b0;
        @(negedge ref_clk_i);
        check(32'(peak_limit_code_o), 32'(CODE_FULL_SCALE));
        check(32'({switch_node_on_o, done_n_oe_o}), 32'h0);
        av_cycle(1'b0, REG_CTRL_OFS, '0, rd);
        check(rd, 32'h1);
        av_cycle(1'b1, REG_CTRL_OFS, 32'h0, rd);
        av_cycle(1'b0, REG_CTRL_OFS, '0, rd);
        check(rd, 32'h0);
        av_cycle(1'b1, REG_CTRL_OFS, 32'h1, rd);
        av_cycle(1'b1, 4'hc, 32'hffffffff, rd);
        av_cycle(1'b0, 4'hc, '0, rd);
        check(rd, 32'h0);
        av_cycle(1'b1, REG_STATUS_OFS, 32'hffffffff, rd);
        av_cycle(1'b0, REG_STATUS_OFS, '0, rd);
        check(rd, 32'h2000);
        // Timer session with three extra pulses
        u_fcs_host_model.burst(3);
        repeat (100) @(negedge ref_clk_i);
        check(32'(switch_node_on_o), 32'h0);
        wait_sig(0, 1'b1, n);
        in_range(n + 100, SETUP - 52, SETUP - 28);
        check(32'(peak_limit_code_o), 32'h3);
        pk();
        wait_sig(0, 1'b1, n);
        in_range(n, SW - 4, SW + 2);
        @(posedge ref_clk_i) output_trip_level_i <= 1'b1;
        wait_sig(0, 1'b0, n);
        in_range(n, SW - 4, SW + 2);
        check(32'(done_n_oe_o), 32'h0);
        wait_sig(1, 1'b1, n);
        in_range(n, 1, SENSE + 6);
        repeat (2 * SW) @(negedge ref_clk_i);
        check(32'(switch_node_on_o), 32'h0);
        av_cycle(1'b0, REG_STATUS_OFS, '0, rd);
        check(rd, 32'h1304);
        check(32'({done_n_oe_o, done_n_o}), 32'h2);
        // Fire follows the pin in any state
        u_fcs_host_model.set_fire(1'b1);
        repeat (5) @(negedge ref_clk_i);
        check(32'(flash_gate_o), 32'h1);
        u_fcs_host_model.set_fire(1'b0);
        repeat (5) @(negedge ref_clk_i);
        check(32'(flash_gate_o), 32'h0);
        u_fcs_host_model.drop();
        output_trip_level_i <= 1'b0;
        check(32'({done_n_oe_o, peak_limit_code_o}), 32'h0);
        av_cycle(1'b0, REG_STATUS_OFS, '0, rd);
        check(rd, 32'h2000);
        // Fast session on a fresh edge, flux ends the off time early
        low_output_i <= 1'b0;
        u_fcs_host_model.burst(0);
        wait_sig(0, 1'b1, n);
        check(32'(peak_limit_code_o), 32'h0);
        pk();
        repeat (SENSE + 4) @(posedge ref_clk_i);
        flux_reset_i <= 1'b1;
        repeat (2) @(posedge ref_clk_i);
        flux_reset_i <= 1'b0;
        wait_sig(0, 1'b1, n);
        in_range(n, 0, 8);
        pk();
        av_cycle(1'b0, REG_STATUS_OFS, '0, rd);
        check(32'(rd[ST_MODE_BIT]), 32'h1);
        u_fcs_host_model.drop();
        low_output_i <= 1'b1;
        // Lowest limit, then lockout in mid-session
        u_fcs_host_model.burst(15);
        wait_sig(0, 1'b1, n);
        check(32'(peak_limit_code_o), 32'(CODE_MAX));
        @(posedge ref_clk_i) supply_lockout_i <= 1'b1;
        repeat (6) @(negedge ref_clk_i);
        check(32'({switch_node_on_o, peak_limit_code_o}), 32'h0);
        av_cycle(1'b0, REG_STATUS_OFS, '0, rd);
        check(32'(rd[4:0]), 32'h0);
        @(posedge ref_clk_i) supply_lockout_i <= 1'b0;
        repeat (SETUP + 50) @(negedge ref_clk_i);
        check(32'(switch_node_on_o), 32'h0);
        u_fcs_host_model.drop();
        supply_lockout_i <= 1'b1;
        u_fcs_host_model.burst(0);
        repeat (10) @(posedge ref_clk_i);
        supply_lockout_i <= 1'b0;
        repeat (SETUP + 50) @(negedge ref_clk_i);
        check(32'(switch_node_on_o), 32'h0);
        u_fcs_host_model.drop();
        u_fcs_host_model.burst(0);
        wait_sig(0, 1'b1, n);
        in_range(n + 16, SETUP - 12, SETUP + 12);
        pk();
        conclude();
    end
endmodule : flash_charger_sequencer_tb
